// file: verilog/dsco_map.vh
// register map, field positions, factory defaults and timing constants of the distance switch block
`ifndef DSCO_MAP_VH
`define DSCO_MAP_VH

// ****************************************
// register byte offsets
// ****************************************
`define DSCO_ADR_CTRL 8'h00
`define DSCO_ADR_STATUS 8'h04
`define DSCO_ADR_DIST 8'h08
`define DSCO_ADR_LOOP_LO 8'h0c
`define DSCO_ADR_LOOP_HI 8'h10
`define DSCO_ADR_LOOP_CODE 8'h14
// channel n (0..2) sits at (n + 1) * 0x20, field index in address bits [4:2]
`define DSCO_CH_SHIFT 5
`define DSCO_FLD_ACT 3'h0
`define DSCO_FLD_INACT 3'h1
`define DSCO_FLD_HYST 3'h2
`define DSCO_FLD_POL 3'h3
`define DSCO_FLD_DELAY 3'h4
`define DSCO_FLD_RELEASE 3'h5

// ****************************************
// field positions
// ****************************************
`define DSCO_CTRL_FACTORY 0
`define DSCO_POL_SINK 0
`define DSCO_STAT_PIN_LSB 4

// ****************************************
// factory defaults
// ****************************************
`define DSCO_DEF_ACT 16'h01f4
`define DSCO_DEF_INACT 16'hffff
`define DSCO_DEF_HYST 16'h000a
`define DSCO_DEF_POL 1'b0
`define DSCO_DEF_DELAY 16'h0000
`define DSCO_DEF_RELEASE 16'h0000
`define DSCO_DEF_LOOP_LO 16'h0000
`define DSCO_DEF_LOOP_HI 16'h2710

// ****************************************
// timing
// ****************************************
`define DSCO_CLK_KHZ 250000
`define DSCO_TICK_MS 1

`endif

// file: verilog/dsco_switch_chan.v
// one switching output channel: window compare with hysteresis, ms qualification and polarity
`timescale 1ns/1ps
module dsco_switch_chan #(
  parameter DW = 16,
  parameter TW = 16
) (
  // clock and reset
  input wire mclk_i,
  input wire srst_i,
  input wire tick_i,
  // measurement
  input wire [DW-1:0] dist_i,
  // configuration
  input wire [DW-1:0] act_i,
  input wire [DW-1:0] inact_i,
  input wire [DW-1:0] hyst_i,
  input wire sink_i,
  input wire [TW-1:0] delay_i,
  input wire [TW-1:0] release_i,
  // outputs
  output reg active_o,
  output reg pin_o
);

  // ****************************************
  // thresholds
  // ****************************************
  wire [DW:0] hi_sum;
  wire [DW-1:0] lo_th;
  wire [DW-1:0] hi_th;
  wire want;
  reg [TW-1:0] cnt_reg;
  wire [TW-1:0] limit;

  // an active output widens its window so a jittering target does not chatter
  assign hi_sum = {1'b0, inact_i} + {1'b0, hyst_i};
  assign lo_th = !active_o ? act_i : (act_i > hyst_i ? act_i - hyst_i : {DW{1'b0}});
  assign hi_th = !active_o ? inact_i : (hi_sum[DW] ? {DW{1'b1}} : hi_sum[DW-1:0]);
  // active from the activation point up to the deactivation point
  assign want = (dist_i >= lo_th) && (dist_i < hi_th);
  assign limit = want ? delay_i : release_i;

  // ****************************************
  // qualification
  // ****************************************
  always @(posedge mclk_i) begin
    if (srst_i) begin
      cnt_reg <= {TW{1'b0}};
      active_o <= 1'b0;
      pin_o <= 1'b0;
    end else begin
      if (want == active_o) begin
        cnt_reg <= {TW{1'b0}};
      end else if (cnt_reg >= limit) begin
        active_o <= want;
        cnt_reg <= {TW{1'b0}};
      end else if (tick_i) begin
        cnt_reg <= cnt_reg + 1'b1;
      end
      // sourcing drives high when active, sinking drives low when active
      pin_o <= active_o ^ sink_i;
    end
  end

endmodule

// file: verilog/dsco_top.v
// distance switch block: wishbone registers, 4-20 mA loop code and three switching outputs
`timescale 1ns/1ps
`include "dsco_map.vh"
module dsco_top #(
  parameter DW = 16,
  parameter TW = 16,
  parameter NCH = 3,
  parameter CLK_PER_MS = `DSCO_CLK_KHZ * `DSCO_TICK_MS,
  parameter [15:0] CODE_4MA = 16'h3333,
  parameter [15:0] CODE_20MA = 16'hffff
) (
  // clock and reset
  input wire mclk_i,
  input wire srst_i,
  // wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [3:0] wb_sel_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // measurement from the distance pipeline
  input wire [DW-1:0] dist_i,
  input wire dist_valid_i,
  // plc side
  output reg [15:0] loop_code_o,
  output wire [NCH-1:0] sw_pin_o
);

  // ****************************************
  // millisecond tick
  // ****************************************
  reg [31:0] div_reg;
  reg tick_reg;

  always @(posedge mclk_i) begin
    if (srst_i) begin
      div_reg <= 32'h0000_0000;
      tick_reg <= 1'b0;
    end else if (div_reg >= CLK_PER_MS - 1) begin
      div_reg <= 32'h0000_0000;
      tick_reg <= 1'b1;
    end else begin
      div_reg <= div_reg + 32'h0000_0001;
      tick_reg <= 1'b0;
    end
  end

  // ****************************************
  // measured distance
  // ****************************************
  reg [DW-1:0] dist_reg;

  always @(posedge mclk_i) begin
    if (srst_i) begin
      dist_reg <= {DW{1'b0}};
    end else if (dist_valid_i) begin
      dist_reg <= dist_i;
    end
  end

  // ****************************************
  // configuration store
  // ****************************************
  reg [DW-1:0] loop_lo_reg;
  reg [DW-1:0] loop_hi_reg;
  reg [DW-1:0] act_reg [0:NCH-1];
  reg [DW-1:0] inact_reg [0:NCH-1];
  reg [DW-1:0] hyst_reg [0:NCH-1];
  reg [NCH-1:0] sink_reg;
  reg [TW-1:0] delay_reg [0:NCH-1];
  reg [TW-1:0] release_reg [0:NCH-1];
  wire [NCH-1:0] active;

  // byte lane merge of a write into a 16-bit field
  function [15:0] wmerge;
    input [15:0] old;
    input [31:0] dat;
    input [3:0] sel;
    begin
      wmerge[7:0] = sel[0] ? dat[7:0] : old[7:0];
      wmerge[15:8] = sel[1] ? dat[15:8] : old[15:8];
    end
  endfunction

  // ****************************************
  // bus decode
  // ****************************************
  wire req;
  wire wr_go;
  wire [2:0] ch_sel;
  wire [2:0] fld;
  wire ch_hit;
  wire [1:0] ch;

  assign req = wb_cyc_i && wb_stb_i;
  // a write lands on the edge where the master sees ack
  assign wr_go = req && wb_ack_o && wb_we_i;
  assign ch_sel = wb_adr_i[7:`DSCO_CH_SHIFT];
  assign fld = wb_adr_i[4:2];
  assign ch_hit = (ch_sel != 3'h0) && ({2'b00, ch_sel} <= NCH) && (fld <= `DSCO_FLD_RELEASE)
    && (wb_adr_i[1:0] == 2'b00);
  assign ch = ch_hit ? ch_sel[1:0] - 2'b01 : 2'b00;

  integer i;

  always @(posedge mclk_i) begin
    if (srst_i || (wr_go && wb_adr_i == `DSCO_ADR_CTRL && wb_sel_i[0]
      && wb_dat_i[`DSCO_CTRL_FACTORY])) begin
      // power up and the settings reset command both restore factory values
      loop_lo_reg <= `DSCO_DEF_LOOP_LO;
      loop_hi_reg <= `DSCO_DEF_LOOP_HI;
      for (i = 0; i < NCH; i = i + 1) begin
        act_reg[i] <= `DSCO_DEF_ACT;
        inact_reg[i] <= `DSCO_DEF_INACT;
        hyst_reg[i] <= `DSCO_DEF_HYST;
        sink_reg[i] <= `DSCO_DEF_POL;
        delay_reg[i] <= `DSCO_DEF_DELAY;
        release_reg[i] <= `DSCO_DEF_RELEASE;
      end
    end else if (wr_go) begin
      // every write is live on the next edge, no separate commit step
      if (wb_adr_i == `DSCO_ADR_LOOP_LO) begin
        loop_lo_reg <= wmerge(loop_lo_reg, wb_dat_i, wb_sel_i);
      end
      if (wb_adr_i == `DSCO_ADR_LOOP_HI) begin
        loop_hi_reg <= wmerge(loop_hi_reg, wb_dat_i, wb_sel_i);
      end
      if (ch_hit) begin
        case (fld)
          `DSCO_FLD_ACT: begin
            act_reg[ch] <= wmerge(act_reg[ch], wb_dat_i, wb_sel_i);
          end
          `DSCO_FLD_INACT: begin
            inact_reg[ch] <= wmerge(inact_reg[ch], wb_dat_i, wb_sel_i);
          end
          `DSCO_FLD_HYST: begin
            hyst_reg[ch] <= wmerge(hyst_reg[ch], wb_dat_i, wb_sel_i);
          end
          `DSCO_FLD_POL: begin
            if (wb_sel_i[0]) begin
              sink_reg[ch] <= wb_dat_i[`DSCO_POL_SINK];
            end
          end
          `DSCO_FLD_DELAY: begin
            delay_reg[ch] <= wmerge(delay_reg[ch], wb_dat_i, wb_sel_i);
          end
          `DSCO_FLD_RELEASE: begin
            release_reg[ch] <= wmerge(release_reg[ch], wb_dat_i, wb_sel_i);
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ****************************************
  // read mux
  // ****************************************
  reg [31:0] rd_next;

  always @* begin
    rd_next = 32'h0000_0000;
    if (ch_hit) begin
      case (fld)
        `DSCO_FLD_ACT: rd_next[DW-1:0] = act_reg[ch];
        `DSCO_FLD_INACT: rd_next[DW-1:0] = inact_reg[ch];
        `DSCO_FLD_HYST: rd_next[DW-1:0] = hyst_reg[ch];
        `DSCO_FLD_POL: rd_next[`DSCO_POL_SINK] = sink_reg[ch];
        `DSCO_FLD_DELAY: rd_next[TW-1:0] = delay_reg[ch];
        `DSCO_FLD_RELEASE: rd_next[TW-1:0] = release_reg[ch];
        default: rd_next = 32'h0000_0000;
      endcase
    end else begin
      case (wb_adr_i)
        `DSCO_ADR_STATUS: begin
          rd_next[NCH-1:0] = active;
          rd_next[`DSCO_STAT_PIN_LSB+NCH-1:`DSCO_STAT_PIN_LSB] = sw_pin_o;
        end
        `DSCO_ADR_DIST: rd_next[DW-1:0] = dist_reg;
        `DSCO_ADR_LOOP_LO: rd_next[DW-1:0] = loop_lo_reg;
        `DSCO_ADR_LOOP_HI: rd_next[DW-1:0] = loop_hi_reg;
        `DSCO_ADR_LOOP_CODE: rd_next[15:0] = loop_code_o;
        default: rd_next = 32'h0000_0000;
      endcase
    end
  end

  // ****************************************
  // wishbone answer
  // ****************************************
  // unmapped offsets are acked and read as zero, so a stray access never hangs the bus
  always @(posedge mclk_i) begin
    if (srst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req && !wb_ack_o;
      if (req && !wb_ack_o) begin
        wb_dat_o <= wb_we_i ? 32'h0000_0000 : rd_next;
      end
    end
  end

  // ****************************************
  // loop current interpolation
  // ****************************************
  localparam ST_IDLE = 1'b0;
  localparam ST_DIV = 1'b1;

  reg st_reg;
  reg [5:0] bit_reg;
  reg [31:0] num_reg;
  reg [DW:0] rem_reg;
  reg [31:0] quo_reg;
  reg [DW-1:0] span_reg;
  reg cdir_reg;
  wire up;
  wire [DW-1:0] span;
  wire [DW-1:0] off;
  wire below;
  wire [15:0] crng;
  wire cdir;
  wire [DW:0] rem_sh;
  wire [15:0] q16;
  reg done_reg;
  wire [15:0] interp;

  // the span may run either way, 4 mA at the far or the near distance
  assign up = loop_hi_reg >= loop_lo_reg;
  assign span = up ? loop_hi_reg - loop_lo_reg : loop_lo_reg - loop_hi_reg;
  assign below = up ? (dist_reg <= loop_lo_reg) : (dist_reg >= loop_lo_reg);
  assign off = up ? dist_reg - loop_lo_reg : loop_lo_reg - dist_reg;
  assign cdir = CODE_20MA >= CODE_4MA;
  assign crng = cdir ? CODE_20MA - CODE_4MA : CODE_4MA - CODE_20MA;
  assign rem_sh = {rem_reg[DW-1:0], num_reg[31]};
  assign q16 = quo_reg[15:0];

  // one restoring division per pass; the code refreshes every few dozen cycles
  always @(posedge mclk_i) begin
    if (srst_i) begin
      st_reg <= ST_IDLE;
      bit_reg <= 6'h00;
      num_reg <= 32'h0000_0000;
      rem_reg <= {(DW+1){1'b0}};
      quo_reg <= 32'h0000_0000;
      span_reg <= {DW{1'b0}};
      cdir_reg <= 1'b0;
      loop_code_o <= CODE_4MA;
    end else begin
      // the interpolated value is published one cycle after the last quotient bit; a clamp below wins
      if (done_reg) begin
        loop_code_o <= interp;
      end
      case (st_reg)
        ST_IDLE: begin
          if (below || span == {DW{1'b0}}) begin
            loop_code_o <= CODE_4MA;
          end else if (off >= span) begin
            loop_code_o <= CODE_20MA;
          end else begin
            num_reg <= off * crng;
            span_reg <= span;
            cdir_reg <= cdir;
            rem_reg <= {(DW+1){1'b0}};
            quo_reg <= 32'h0000_0000;
            bit_reg <= 6'h00;
            st_reg <= ST_DIV;
          end
        end
        ST_DIV: begin
          num_reg <= {num_reg[30:0], 1'b0};
          if (rem_sh >= {1'b0, span_reg}) begin
            rem_reg <= rem_sh - {1'b0, span_reg};
            quo_reg <= {quo_reg[30:0], 1'b1};
          end else begin
            rem_reg <= rem_sh;
            quo_reg <= {quo_reg[30:0], 1'b0};
          end
          bit_reg <= bit_reg + 6'h01;
          if (bit_reg == 6'h1f) begin
            st_reg <= ST_IDLE;
          end
        end
        default: begin
          st_reg <= ST_IDLE;
        end
      endcase
      if (st_reg == ST_IDLE && bit_reg == 6'h20) begin
        bit_reg <= 6'h00;
      end
    end
  end

  // ****************************************
  // loop code update at end of division
  // ****************************************
  // quotient is below the code range, so the sum never wraps
  assign interp = cdir_reg ? CODE_4MA + q16 : CODE_4MA - q16;

  always @(posedge mclk_i) begin
    if (srst_i) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= (st_reg == ST_DIV) && (bit_reg == 6'h1f);
    end
  end

  // ****************************************
  // switching channels
  // ****************************************
  // the full-range deactivation default gives single point use out of reset
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_ch
      dsco_switch_chan #(
        .DW(DW),
        .TW(TW)
      ) u_chan (
        .mclk_i(mclk_i),
        .srst_i(srst_i),
        .tick_i(tick_reg),
        .dist_i(dist_reg),
        .act_i(act_reg[g]),
        .inact_i(inact_reg[g]),
        .hyst_i(hyst_reg[g]),
        .sink_i(sink_reg[g]),
        .delay_i(delay_reg[g]),
        .release_i(release_reg[g]),
        .active_o(active[g]),
        .pin_o(sw_pin_o[g])
      );
    end
  endgenerate

endmodule

// file: tb/dsco_top_asserts.sv
// concurrent checks on the ports of the distance switch block
`timescale 1ns/1ps
module dsco_top_asserts #(
  parameter NCH = 3,
  parameter [15:0] CODE_4MA = 16'h3333,
  parameter [15:0] CODE_20MA = 16'hffff
) (
  // clock and reset
  input wire mclk_i,
  input wire srst_i,
  // bus
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  // plc side
  input wire [15:0] loop_code_o,
  input wire [NCH-1:0] sw_pin_o
);
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (srst_i);
  property p_ack_next;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("no ack after request");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_ack_cause;
    $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_rst_out;
    $fell(srst_i) |-> sw_pin_o == {NCH{1'b0}} && loop_code_o == CODE_4MA && !wb_ack_o;
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("outputs wrong after reset");
  // clamping means the code never leaves the 4 to 20 mA band
  property p_loop_range;
    loop_code_o >= CODE_4MA && loop_code_o <= CODE_20MA;
  endproperty
  a_loop_range: assert property (p_loop_range) else $error("loop code outside band");
  property p_wr_zero;
    wb_ack_o && $past(wb_we_i) |-> wb_dat_o == 32'h0;
  endproperty
  a_wr_zero: assert property (p_wr_zero) else $error("write answer not zero");
  property p_status_pins;
    wb_ack_o && $past(!wb_we_i && wb_adr_i == 8'h04) |-> wb_dat_o[4 +: NCH] == $past(sw_pin_o);
  endproperty
  a_status_pins: assert property (p_status_pins) else $error("status pins differ");
  property p_zero_read;
    wb_ack_o && $past(!wb_we_i && (wb_adr_i == 8'h00 || wb_adr_i == 8'h18)) |-> wb_dat_o == 32'h0;
  endproperty
  a_zero_read: assert property (p_zero_read) else $error("command or hole reads nonzero");
endmodule

bind dsco_top dsco_top_asserts #(.NCH(NCH), .CODE_4MA(CODE_4MA), .CODE_20MA(CODE_20MA)) i_dsco_top_asserts (
  .mclk_i(mclk_i), .srst_i(srst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .loop_code_o(loop_code_o), .sw_pin_o(sw_pin_o)
);

// file: tb/dsco_plc_model.sv
// plc input card model: samples the switching inputs and the loop current code
`timescale 1ns/1ps
module dsco_plc_model #(
  parameter NCH = 3
) (
  // clock
  input wire mclk_i,
  // plc inputs
  input wire [NCH-1:0] sw_pin_i,
  input wire [15:0] loop_code_i,
  // sampled view
  output reg [NCH-1:0] plc_sw_o,
  output reg [15:0] plc_loop_o
);
  // one separate input per channel, latched once a clock; adds a cycle of lag
  always @(posedge mclk_i) begin
    plc_sw_o <= sw_pin_i;
    plc_loop_o <= loop_code_i;
  end
endmodule

// file: tb/dsco_top_test.sv
// self-checking bench of the distance switch block
`timescale 1ns/1ps
`include "dsco_map.vh"
module dsco_top_test;
  localparam [15:0] C4 = 16'h3333;
  localparam [15:0] C20 = 16'hffff;
  reg mclk_i = 1'b0;
  reg srst_i = 1'b1;
  reg wb_cyc_i = 1'b0;
  reg wb_stb_i = 1'b0;
  reg wb_we_i = 1'b0;
  reg [7:0] wb_adr_i = 8'h00;
  reg [31:0] wb_dat_i = 32'h0;
  reg [3:0] wb_sel_i = 4'h0;
  reg [15:0] dist_i = 16'h0;
  reg dist_valid_i = 1'b0;
  wire [31:0] wb_dat_o;
  wire wb_ack_o;
  wire [15:0] loop_code_o;
  wire [2:0] sw_pin_o;
  wire [2:0] plc_sw;
  wire [15:0] plc_loop;
  integer bad_count = 0;
  integer n_compared = 0;
  reg [31:0] rd;
  reg [3:0] sel_use = 4'h3;
  always #2 mclk_i = ~mclk_i;
  // a short millisecond keeps the delay scenarios brief
  dsco_top #(.CLK_PER_MS(10)) i_dsco_top (.mclk_i(mclk_i), .srst_i(srst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .dist_i(dist_i), .dist_valid_i(dist_valid_i), .loop_code_o(loop_code_o), .sw_pin_o(sw_pin_o));
  dsco_plc_model i_dsco_plc_model (.mclk_i(mclk_i), .sw_pin_i(sw_pin_o), .loop_code_i(loop_code_o),
    .plc_sw_o(plc_sw), .plc_loop_o(plc_loop));
  // ****************************************
  // shared tasks
  // ****************************************
  task finish_test;
    begin
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
        $display("Run complete: PASS");
      end else begin
        $display("Run complete: FAIL");
      end
      $finish;
    end
  endtask
  task check(input [31:0] got, input [31:0] exp, input string what);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
    end
  endtask
  task wb_cycle(input we, input [7:0] adr, input [31:0] dat);
    integer n;
    begin
      @(posedge mclk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= dat;
      wb_sel_i <= sel_use;
      n = 0;
      @(posedge mclk_i);
      while (wb_ack_o !== 1'b1 && n < 20) begin
        n = n + 1;
        @(posedge mclk_i);
      end
      if (wb_ack_o !== 1'b1) begin
        bad_count = bad_count + 1;
        $display("Error at %0t: bus answer timed out", $time);
        finish_test;
      end
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
    end
  endtask
  task rdchk(input [7:0] a, input [31:0] e);
    begin
      wb_cycle(1'b0, a, 32'h0);
      check(rd, e, "register read");
    end
  endtask
  function [7:0] ca(input [2:0] ch, input [2:0] f);
    ca = {ch + 3'd1, f, 2'b00};
  endfunction
  task meas(input [15:0] d);
    begin
      @(posedge mclk_i);
      dist_i <= d;
      dist_valid_i <= 1'b1;
      @(posedge mclk_i);
      dist_valid_i <= 1'b0;
    end
  endtask
  task pins(input [15:0] d, input [2:0] e);
    begin
      meas(d);
      repeat (6) @(posedge mclk_i);
      check({29'h0, plc_sw}, {29'h0, e}, "pins");
    end
  endtask
  task w2(input integer n, input e);
    begin
      repeat (n) @(posedge mclk_i);
      check({31'h0, plc_sw[2]}, {31'h0, e}, "delayed pin");
    end
  endtask
  function [15:0] lin(input [15:0] d);
    reg [31:0] t;
    begin
      t = (({16'h0, d} - 32'd1000) * {16'h0, C20 - C4}) / 32'd1000;
      if (d <= 16'd1000) lin = C4;
      else if (d >= 16'd2000) lin = C20;
      else lin = C4 + t[15:0];
    end
  endfunction
  task loopc(input [15:0] d);
    begin
      meas(d);
      // a division already under way has to finish before the new one starts
      repeat (70) @(posedge mclk_i);
      check({16'h0, plc_loop}, {16'h0, lin(d)}, "loop output");
      rdchk(`DSCO_ADR_LOOP_CODE, {16'h0, lin(d)});
    end
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task t_defaults;
    reg [2:0] c;
    begin
      for (c = 3'd0; c < 3'd3; c = c + 3'd1) begin
        rdchk(ca(c, `DSCO_FLD_ACT), {16'h0, `DSCO_DEF_ACT});
        rdchk(ca(c, `DSCO_FLD_INACT), {16'h0, `DSCO_DEF_INACT});
        rdchk(ca(c, `DSCO_FLD_HYST), {16'h0, `DSCO_DEF_HYST});
        rdchk(ca(c, `DSCO_FLD_POL), {31'h0, `DSCO_DEF_POL});
        rdchk(ca(c, `DSCO_FLD_DELAY), {16'h0, `DSCO_DEF_DELAY});
        rdchk(ca(c, `DSCO_FLD_RELEASE), {16'h0, `DSCO_DEF_RELEASE});
      end
      rdchk(`DSCO_ADR_LOOP_LO, {16'h0, `DSCO_DEF_LOOP_LO});
      rdchk(`DSCO_ADR_LOOP_HI, {16'h0, `DSCO_DEF_LOOP_HI});
      $display("test defaults done");
    end
  endtask
  task t_window;
    begin
      wb_cycle(1'b1, ca(3'd0, `DSCO_FLD_ACT), 32'd100);
      wb_cycle(1'b1, ca(3'd0, `DSCO_FLD_INACT), 32'd200);
      wb_cycle(1'b1, ca(3'd0, `DSCO_FLD_HYST), 32'd0);
      wb_cycle(1'b1, ca(3'd1, `DSCO_FLD_ACT), 32'd300);
      wb_cycle(1'b1, ca(3'd1, `DSCO_FLD_INACT), 32'h0000ffff);
      rdchk(ca(3'd0, `DSCO_FLD_INACT), 32'd200);
      pins(16'd99, 3'b000);
      pins(16'd100, 3'b001);
      pins(16'd199, 3'b001);
      pins(16'd200, 3'b000);
      pins(16'd300, 3'b010);
      pins(16'd500, 3'b110);
      rdchk(`DSCO_ADR_STATUS, 32'h00000066);
      $display("test window done");
    end
  endtask
  task t_hyst;
    begin
      wb_cycle(1'b1, ca(3'd0, `DSCO_FLD_HYST), 32'd10);
      pins(16'd100, 3'b001);
      pins(16'd95, 3'b001);
      pins(16'd205, 3'b001);
      pins(16'd89, 3'b000);
      pins(16'd95, 3'b000);
      $display("test hysteresis done");
    end
  endtask
  task t_sink;
    begin
      wb_cycle(1'b1, ca(3'd1, `DSCO_FLD_POL), 32'h1);
      pins(16'd95, 3'b010);
      pins(16'd400, 3'b000);
      $display("test sinking done");
    end
  endtask
  task t_qual;
    begin
      wb_cycle(1'b1, ca(3'd2, `DSCO_FLD_DELAY), 32'd3);
      wb_cycle(1'b1, ca(3'd2, `DSCO_FLD_RELEASE), 32'd2);
      meas(16'd600);
      w2(15, 1'b0);
      // each break lands before the earliest switch any tick phase allows
      meas(16'd400);
      meas(16'd600);
      w2(21, 1'b0);
      w2(14, 1'b1);
      meas(16'd100);
      w2(8, 1'b1);
      meas(16'd600);
      meas(16'd100);
      w2(14, 1'b1);
      w2(12, 1'b0);
      $display("test qualification done");
    end
  endtask
  task t_loop;
    begin
      wb_cycle(1'b1, `DSCO_ADR_LOOP_LO, 32'd1000);
      wb_cycle(1'b1, `DSCO_ADR_LOOP_HI, 32'd2000);
      loopc(16'd500);
      loopc(16'd1000);
      loopc(16'd1250);
      loopc(16'd1500);
      loopc(16'd2000);
      loopc(16'd3000);
      $display("test loop done");
    end
  endtask
  task t_factory;
    begin
      wb_cycle(1'b1, `DSCO_ADR_CTRL, 32'h1);
      rdchk(`DSCO_ADR_CTRL, 32'h0);
      t_defaults;
      pins(16'd150, 3'b000);
      wb_cycle(1'b1, 8'h18, 32'h00001234);
      rdchk(8'h18, 32'h0);
      wb_cycle(1'b1, ca(3'd0, `DSCO_FLD_ACT), 32'd100);
      wb_cycle(1'b1, ca(3'd0, `DSCO_FLD_INACT), 32'd200);
      pins(16'd150, 3'b001);
      rdchk(`DSCO_ADR_DIST, 32'd150);
      sel_use = 4'h1;
      wb_cycle(1'b1, ca(3'd2, `DSCO_FLD_HYST), 32'h0000ab77);
      sel_use = 4'h3;
      rdchk(ca(3'd2, `DSCO_FLD_HYST), 32'h00000077);
      $display("test factory done");
    end
  endtask
  // ****************************************
  // main sequence and timeout
  // ****************************************
  initial begin
    repeat (6) @(posedge mclk_i);
    srst_i <= 1'b0;
    t_defaults;
    t_window;
    t_hyst;
    t_sink;
    t_qual;
    t_loop;
    t_factory;
    finish_test;
  end
  initial begin
    repeat (100000) @(posedge mclk_i);
    bad_count = bad_count + 1;
    $display("Error at %0t: run timed out", $time);
    finish_test;
  end
endmodule
